// ---- design/eeo_top.v ----
/*
 Encoder emulation output: turns the shaft position into an A/B/index
 quadrature stream or a serial absolute frame, set up over APB.
 Assumes a same-clock shaft position input, an external serial shift
 clock and encoder index arriving asynchronously on pins.
 The evaluator must keep its shift clock high between bursts for at
 least the idle timeout, or the next burst is taken as more bits.
 Motion faster than the edge limit is not lost: the outputs lag and
 catch up once the shaft slows down.
 Index offset writes raise a one-cycle store request; keeping the value
 through power loss is left to the storage outside this block.
*/
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "eeo_defines.vh"

module eeo_top #(
	parameter TIMEOUT = `EEO_TIMEOUT_CYC,
	parameter ENC_LOG = 11
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Shaft position: revolutions and 16-bit within-turn angle
	input wire [15:0] shaft_turns,
	input wire [15:0] shaft_angle,
	// Encoder index from the feedback connector (asynchronous)
	input wire enc_index,
	// Emulation outputs
	output reg out_a,
	output reg out_b,
	output reg index_pulse,
	input wire ssi_clk,
	output reg ssi_data,
	output reg nvm_save_req
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// Software settings
	reg [11:0] ctrl_reg;
	reg [4:0] lines_reg;
	reg [15:0] idxofs_reg;
	reg [7:0] clkdiv_reg;
	// Step tracking: emitted count against target
	reg [31:0] pos_acc_reg;
	reg [31:0] tgt_reg;
	reg step_req_reg;
	reg step_dir_reg;

	// Pin synchronisers and edge history
	reg [1:0] sclk_sync_reg;
	reg sclk_prev_reg;
	reg [1:0] idx_sync_reg;
	// Shift clock spacing check and frame capture
	reg [15:0] sgap_reg;
	reg overspeed_reg;
	reg [31:0] frame_hold_reg;

	// Submodule outputs
	wire [1:0] phase;
	wire step_ack;
	wire sdata;
	wire sbusy;
	wire slatch;
	// Control fields
	wire [1:0] mode = ctrl_reg[`EEO_CTRL_MODE_MSB:`EEO_CTRL_MODE_LSB];
	wire [4:0] rev_bits = ctrl_reg[`EEO_CTRL_REV_MSB:`EEO_CTRL_REV_LSB];
	wire [2:0] imul = ctrl_reg[`EEO_CTRL_IMUL_MSB:`EEO_CTRL_IMUL_LSB];
	wire invert = ctrl_reg[`EEO_CTRL_INVERT_BIT];
	wire [31:0] abs_pos = {shaft_turns, shaft_angle};

	// Clamp a field to a legal range
	// Shared by the line count, multiplier and revolution width limits
	function [4:0] clamp5;
		input [4:0] v;
		input [4:0] lo;
		input [4:0] hi;
		begin
			if (v < lo)
				clamp5 = lo;
			else if (v > hi)
				clamp5 = hi;
			else
				clamp5 = v;
		end
	endfunction

	// Encoder line count log2 as a five-bit field for the sums below
	localparam [4:0] ENC_LOG_W = ENC_LOG[4:0];
	// Interpolation multiplier held to its legal range
	wire [4:0] imul_eff = clamp5({2'b00, imul}, {2'b00, `EEO_IMUL_MIN},
		{2'b00, `EEO_IMUL_MAX});
	// Effective log2 of lines per turn for the current mode
	wire [4:0] lines_log = (mode == `EEO_MODE_INTERP) ?
		(ENC_LOG_W + imul_eff) :
		clamp5(lines_reg, `EEO_LINES_MIN_LOG, `EEO_LINES_MAX_LOG);

	// ------------------------------------------------------------------
	// Target count: position scaled to quadrature states (4 per line)
	// ------------------------------------------------------------------
	// Direction flip is opt-in; reset default counts up clockwise
	// Inverting negates the whole word, revolutions included
	reg [31:0] dir_pos;
	reg [31:0] tgt_next;
	always @* begin
		dir_pos = invert ? (32'h0 - abs_pos) : abs_pos;
		// Angle holds 16 bits per turn; states per turn are 2^(log+2)
		if (lines_log + 5'h02 >= 5'h10)
			tgt_next = dir_pos << (lines_log + 5'h02 - 5'h10);
		else
			tgt_next = dir_pos >> (5'h10 - lines_log - 5'h02);
	end

	// ------------------------------------------------------------------
	// Step request toward target
	// ------------------------------------------------------------------
	// Follows target one quadrature state at a time; lag absorbs speed
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tgt_reg <= 32'h00000000;
			pos_acc_reg <= 32'h00000000;
			step_req_reg <= 1'b0;
			step_dir_reg <= 1'b0;
		end else begin
			tgt_reg <= tgt_next;
			// Count what was actually emitted, not what was asked for
			if (step_ack)
				pos_acc_reg <= step_dir_reg ? pos_acc_reg - 32'h1 : pos_acc_reg + 32'h1;
			step_req_reg <= (mode == `EEO_MODE_INCR || mode == `EEO_MODE_INTERP) &&
				(tgt_reg != pos_acc_reg) && !step_ack;
			step_dir_reg <= ($signed(tgt_reg - pos_acc_reg) < 0);
		end
	end

	// Minimum spacing between steps caps the A/B edge rate
	eeo_quad_gen #(
		.MIN_STEP(`EEO_MIN_STEP_CYC)
	) u_quad (
		.clk(clk),
		.reset_n(reset_n),
		.step_req(step_req_reg),
		.step_dir(step_dir_reg),
		.step_ack(step_ack),
		.phase_reg(phase)
	);

	// ------------------------------------------------------------------
	// Index generation
	// ------------------------------------------------------------------
	// Offset converted from angle units to quadrature states, and turn mask
	reg [31:0] ofs_states;
	reg [31:0] turn_mask;
	always @* begin
		if (lines_log + 5'h02 >= 5'h10)
			ofs_states = {16'h0000, idxofs_reg} << (lines_log + 5'h02 - 5'h10);
		else
			ofs_states = {16'h0000, idxofs_reg} >> (5'h10 - lines_log - 5'h02);
		turn_mask = (32'h1 << (lines_log + 5'h02)) - 32'h1;
	end
	// Emitted count relative to the offset, folded into one turn
	wire [31:0] turn_state = pos_acc_reg - ofs_states;
	// Last four states before the offset; exactly one of them has A=B=1,
	// so the index comes once per turn at any line count
	wire near_top = ((turn_state | 32'h3) & turn_mask) == turn_mask;

	// ------------------------------------------------------------------
	// Output registers and pin synchronisers
	// ------------------------------------------------------------------
	// Pin levels pass two flip-flops before anything reads them
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			out_a <= 1'b0;
			out_b <= 1'b0;
			index_pulse <= 1'b0;
			ssi_data <= 1'b1;
			idx_sync_reg <= 2'h0;
			sclk_sync_reg <= 2'h3;
			sclk_prev_reg <= 1'b1;
		end else begin
			idx_sync_reg <= {idx_sync_reg[0], enc_index};
			sclk_sync_reg <= {sclk_sync_reg[0], ssi_clk};
			sclk_prev_reg <= sclk_sync_reg[1];
			out_a <= phase[1];
			out_b <= phase[0];
			if (mode == `EEO_MODE_INTERP)
				index_pulse <= idx_sync_reg[1];
			else if (mode == `EEO_MODE_INCR)
				// Emitted count, not raw angle: a jump the outputs chase still indexes
				index_pulse <= phase[1] && phase[0] && near_top;
			else
				index_pulse <= 1'b0;
			// Serial line rests high outside serial mode
			ssi_data <= (mode == `EEO_MODE_SERIAL) ? sdata : 1'b1;
		end
	end

	// Edges taken from the second synchroniser stage only
	wire sclk_fall = sclk_prev_reg && !sclk_sync_reg[1];
	wire sclk_rise = !sclk_prev_reg && sclk_sync_reg[1];

	// ------------------------------------------------------------------
	// Serial frame build
	// ------------------------------------------------------------------
	// Word is right aligned here; the shifter left aligns short frames
	reg [31:0] bin_word;
	reg [31:0] frame_word;
	reg [4:0] rb;
	always @* begin
		rb = clamp5(rev_bits, `EEO_REV_MIN, `EEO_REV_MAX);
		// Turns lead, fixed 16 angle bits follow, right aligned
		bin_word = ({16'h0000, dir_pos[31:16]} & ((32'h1 << rb) - 32'h1)) << 16;
		bin_word = bin_word | {16'h0000, dir_pos[15:0]};
		frame_word = ctrl_reg[`EEO_CTRL_GRAY_BIT] ?
			(bin_word ^ (bin_word >> 1)) : bin_word;
	end

	// Shift clock edges count only in serial mode
	eeo_ssi_shift #(
		.WIDTH(`EEO_FRAME_MAX),
		.TIMEOUT(TIMEOUT)
	) u_ssi (
		.clk(clk),
		.reset_n(reset_n),
		.sclk_fall(sclk_fall && mode == `EEO_MODE_SERIAL),
		.sclk_rise(sclk_rise && mode == `EEO_MODE_SERIAL),
		.frame_word(frame_word),
		.frame_len({1'b0, rb} + 6'h10),
		.sdata_reg(sdata),
		.busy_reg(sbusy),
		.latch_pulse(slatch)
	);

	// ------------------------------------------------------------------
	// Shift clock rate check against the configured divider
	// ------------------------------------------------------------------
	// Edges closer than the setting flag overspeed; sticky until cleared
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sgap_reg <= 16'h0000;
			overspeed_reg <= 1'b0;
			frame_hold_reg <= 32'h00000000;
		end else begin
			if (slatch)
				frame_hold_reg <= frame_word;
			// Same-cycle set beats the clear, so no fast edge goes unseen
			if (sclk_rise || sclk_fall) begin
				sgap_reg <= 16'h0000;
				if (sbusy && sgap_reg < {8'h00, clkdiv_reg})
					overspeed_reg <= 1'b1;
				else if (psel && penable && pwrite && paddr == `EEO_OFS_STATUS && pwdata[0])
					overspeed_reg <= 1'b0;
			end else begin
				if (sgap_reg != 16'hffff)
					sgap_reg <= sgap_reg + 16'h0001;
				if (psel && penable && pwrite && paddr == `EEO_OFS_STATUS && pwdata[0])
					overspeed_reg <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// APB slave: zero wait states, error on unmapped addresses
	// ------------------------------------------------------------------
	// Address decode; anything outside the map answers with an error
	wire apb_setup = psel && !penable;
	wire mapped = (paddr == `EEO_OFS_CTRL) || (paddr == `EEO_OFS_LINES) ||
		(paddr == `EEO_OFS_IDXOFS) || (paddr == `EEO_OFS_CLKDIV) ||
		(paddr == `EEO_OFS_STATUS) || (paddr == `EEO_OFS_POS);
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= `EEO_CTRL_RESET;
			lines_reg <= `EEO_LINES_RESET;
			idxofs_reg <= `EEO_IDXOFS_RESET;
			clkdiv_reg <= `EEO_CLKDIV_RESET;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			nvm_save_req <= 1'b0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && !mapped;
			nvm_save_req <= 1'b0;
			// Writes here land at the setup edge; the access cycle only answers
			if (apb_setup && pwrite) begin
				if (paddr == `EEO_OFS_CTRL)
					ctrl_reg <= pwdata[11:0];
				else if (paddr == `EEO_OFS_LINES)
					lines_reg <= pwdata[4:0];
				else if (paddr == `EEO_OFS_IDXOFS) begin
					idxofs_reg <= pwdata[15:0];
					nvm_save_req <= 1'b1;
				end else if (paddr == `EEO_OFS_CLKDIV)
					clkdiv_reg <= pwdata[7:0];
			end
			// Read data stands only in the answer cycle, zero otherwise
			if (apb_setup && !pwrite) begin
				if (paddr == `EEO_OFS_CTRL)
					prdata <= {20'h00000, ctrl_reg};
				else if (paddr == `EEO_OFS_LINES)
					prdata <= {27'h0000000, lines_log};
				else if (paddr == `EEO_OFS_IDXOFS)
					prdata <= {16'h0000, idxofs_reg};
				else if (paddr == `EEO_OFS_CLKDIV)
					prdata <= {24'h000000, clkdiv_reg};
				else if (paddr == `EEO_OFS_STATUS)
					prdata <= {28'h0000000, index_pulse, sbusy, step_req_reg, overspeed_reg};
				else if (paddr == `EEO_OFS_POS)
					prdata <= frame_hold_reg;
				else
					prdata <= 32'h00000000;
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

endmodule // eeo_top

// ---- inc/eeo_defines.vh ----
/*
 Constants for the encoder emulation output block: register offsets,
 field positions, reset values, mode codes and timing counts.
 Assumes a 200 MHz system clock and a 32-bit APB register bus.
*/
`ifndef EEO_DEFINES_VH
`define EEO_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define EEO_OFS_CTRL 12'h000
`define EEO_OFS_LINES 12'h004
`define EEO_OFS_IDXOFS 12'h008
`define EEO_OFS_CLKDIV 12'h00c
`define EEO_OFS_STATUS 12'h010
`define EEO_OFS_POS 12'h014

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define EEO_CTRL_MODE_LSB 0
`define EEO_CTRL_MODE_MSB 1
`define EEO_CTRL_GRAY_BIT 2
`define EEO_CTRL_INVERT_BIT 3
`define EEO_CTRL_REV_LSB 4
`define EEO_CTRL_REV_MSB 8
`define EEO_CTRL_IMUL_LSB 9
`define EEO_CTRL_IMUL_MSB 11

// ----------------------------------------------------------------------
// Mode codes and limits
// ----------------------------------------------------------------------
`define EEO_MODE_INCR 2'h1
`define EEO_MODE_SERIAL 2'h2
`define EEO_MODE_INTERP 2'h3
`define EEO_REV_MIN 5'h0c
`define EEO_REV_MAX 5'h10
`define EEO_TURN_BITS 16
`define EEO_FRAME_MAX 32
`define EEO_LINES_MIN_LOG 5'h08
`define EEO_LINES_MAX_LOG 5'h13
`define EEO_IMUL_MIN 3'h4
`define EEO_IMUL_MAX 3'h7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EEO_CTRL_RESET 12'h0c1
`define EEO_LINES_RESET 5'h0c
`define EEO_IDXOFS_RESET 16'h0000
`define EEO_CLKDIV_RESET 8'h42

// ----------------------------------------------------------------------
// Timing: 200 MHz clock, 1.5 MHz output frequency limit (6 MHz edges), serial idle timeout
// ----------------------------------------------------------------------
`define EEO_CLK_KHZ 200000
`define EEO_FMAX_KHZ 1500
`define EEO_MIN_STEP_CYC ((`EEO_CLK_KHZ + `EEO_FMAX_KHZ * 4 - 1) / (`EEO_FMAX_KHZ * 4))
`define EEO_TIMEOUT_US 20
`define EEO_TIMEOUT_CYC (`EEO_TIMEOUT_US * `EEO_CLK_KHZ / 1000)

`endif

// ---- design/eeo_quad_gen.v ----
/*
 Quadrature step generator: turns a signed step request into A/B
 transitions, one state change per accepted step, paced by a minimum
 spacing so the output never exceeds its edge rate.
 Assumes step requests from logic on the same clock.
*/
`timescale 1ns/1ps

module eeo_quad_gen #(
	parameter MIN_STEP = 34
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Step request
	input wire step_req,
	input wire step_dir,
	output reg step_ack,
	// Quadrature state, gray two-bit counter
	output reg [1:0] phase_reg
);

	reg [15:0] gap_reg;

	// ------------------------------------------------------------------
	// Phase stepping
	// ------------------------------------------------------------------
	// One 90 degree step per accepted request; spacing keeps edges slow
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_reg <= 2'h0;
			gap_reg <= 16'h0000;
			step_ack <= 1'b0;
		end else begin
			step_ack <= 1'b0;
			if (gap_reg != 16'h0000) begin
				gap_reg <= gap_reg - 16'h0001;
			end else if (step_req && !step_ack) begin
				// Gray sequence 00,01,11,10 gives A/B 90 degrees apart
				case ({step_dir, phase_reg})
				3'b000: phase_reg <= 2'b01;
				3'b001: phase_reg <= 2'b11;
				3'b011: phase_reg <= 2'b10;
				3'b010: phase_reg <= 2'b00;
				3'b100: phase_reg <= 2'b10;
				3'b110: phase_reg <= 2'b11;
				3'b111: phase_reg <= 2'b01;
				default: phase_reg <= 2'b00;
				endcase
				step_ack <= 1'b1;
				gap_reg <= MIN_STEP[15:0] - 16'h0001;
			end
		end
	end

endmodule // eeo_quad_gen

// ---- design/eeo_ssi_shift.v ----
/*
 Serial frame shifter: loads a position word at the first falling shift
 clock edge of a burst, shifts MSB first on each rising edge, and returns
 to idle when the shift clock stays high for the timeout.
 Assumes shift clock edges already synchronised to clk.
*/
`timescale 1ns/1ps

module eeo_ssi_shift #(
	parameter WIDTH = 32,
	parameter TIMEOUT = 4000
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Synchronised shift clock edges
	input wire sclk_fall,
	input wire sclk_rise,
	// Frame word and its length
	input wire [WIDTH-1:0] frame_word,
	input wire [5:0] frame_len,
	// Serial output
	output reg sdata_reg,
	output reg busy_reg,
	output reg latch_pulse
);

	reg [WIDTH-1:0] shift_reg;
	reg [15:0] idle_reg;

	// ------------------------------------------------------------------
	// Frame sequencing
	// ------------------------------------------------------------------
	// First edge latches; word is left aligned so bit WIDTH-1 goes first
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_reg <= {WIDTH{1'b0}};
			idle_reg <= 16'h0000;
			sdata_reg <= 1'b1;
			busy_reg <= 1'b0;
			latch_pulse <= 1'b0;
		end else begin
			latch_pulse <= 1'b0;
			if (sclk_fall && !busy_reg) begin
				shift_reg <= frame_word << (WIDTH - frame_len);
				busy_reg <= 1'b1;
				latch_pulse <= 1'b1;
				idle_reg <= 16'h0000;
			end else if (busy_reg) begin
				if (sclk_rise) begin
					sdata_reg <= shift_reg[WIDTH-1];
					shift_reg <= {shift_reg[WIDTH-2:0], 1'b0};
					idle_reg <= 16'h0000;
				end else if (sclk_fall) begin
					idle_reg <= 16'h0000;
				end else if (idle_reg == TIMEOUT[15:0]) begin
					// Monoflop time: line rests high, next burst relatches
					busy_reg <= 1'b0;
					sdata_reg <= 1'b1;
				end else begin
					idle_reg <= idle_reg + 16'h0001;
				end
			end
		end
	end

endmodule // eeo_ssi_shift

// ---- verification/eeo_checker.sv ----
/* Port checker for the encoder emulation output.
 Assumes it is bound to eeo_top and sees only its ports. */
`timescale 1ns/1ps
module eeo_checker #(
	parameter TIMEOUT = 50
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	// Emulation pins
	input wire enc_index,
	input wire out_a,
	input wire out_b,
	input wire index_pulse,
	input wire ssi_clk,
	input wire ssi_data,
	input wire nvm_save_req
);
	reg [1:0] mode_reg;
	reg a_q;
	reg b_q;
	reg clk_q;
	reg [7:0] gap_reg;
	reg [11:0] hi_reg;
	reg [3:0] rise_reg;
	wire setup = psel && !penable;
	wire ab_chg = (out_a != a_q) || (out_b != b_q);
	// Shadow of the mode field, spacing and shift clock counters
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg <= 2'h1;
			a_q <= 1'b0;
			b_q <= 1'b0;
			clk_q <= 1'b1;
			gap_reg <= 8'hff;
			hi_reg <= 12'h000;
			rise_reg <= 4'hf;
		end else begin
			if (setup && pwrite && paddr == 12'h000)
				mode_reg <= pwdata[1:0];
			a_q <= out_a;
			b_q <= out_b;
			clk_q <= ssi_clk;
			gap_reg <= ab_chg ? 8'h01 : (gap_reg == 8'hff ? gap_reg : gap_reg + 8'h01);
			hi_reg <= !ssi_clk ? 12'h000 : (hi_reg == 12'hfff ? hi_reg : hi_reg + 12'h001);
			rise_reg <= (ssi_clk && !clk_q) ? 4'h0 : (rise_reg == 4'hf ? rise_reg : rise_reg + 4'h1);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_setup; psel && !penable; endsequence
	sequence s_answer; pready ##1 !pready; endsequence
	property p_apb_answer; s_setup |=> s_answer; endproperty
	property p_err_ready; pslverr |-> pready; endproperty
	property p_ab_single; ab_chg |-> (out_a == a_q) || (out_b == b_q); endproperty
	property p_ab_gap; ab_chg |-> gap_reg >= 8'd34; endproperty
	property p_idx_quad; mode_reg == 2'h1 && index_pulse |-> out_a && out_b; endproperty
	property p_idx_pass; (mode_reg == 2'h3) [*5] |-> index_pulse == $past(enc_index, 3); endproperty
	property p_ssi_idle; hi_reg >= TIMEOUT + 8 |-> ssi_data; endproperty
	property p_ssi_move; $changed(ssi_data) |-> rise_reg <= 4'd8 || hi_reg >= TIMEOUT - 4; endproperty
	property p_nvm; setup && pwrite && paddr == 12'h008 |-> ##[1:3] nvm_save_req; endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("setup not answered");
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	a_ab_single: assert property (p_ab_single) else $error("A and B moved together");
	a_ab_gap: assert property (p_ab_gap) else $error("A/B edges too close");
	a_idx_quad: assert property (p_idx_quad) else $error("index outside A=B=1");
	a_idx_pass: assert property (p_idx_pass) else $error("encoder index not passed");
	a_ssi_idle: assert property (p_ssi_idle) else $error("serial data not idle high");
	a_ssi_move: assert property (p_ssi_move) else $error("serial data moved off edge");
	a_nvm: assert property (p_nvm) else $error("offset store not requested");
endmodule // eeo_checker

bind eeo_top eeo_checker #(.TIMEOUT(TIMEOUT)) u_chk (.clk(clk), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .enc_index(enc_index), .out_a(out_a),
	.out_b(out_b), .index_pulse(index_pulse), .ssi_clk(ssi_clk), .ssi_data(ssi_data),
	.nvm_save_req(nvm_save_req));

// ---- verification/eeo_ssi_master.sv ----
/* Serial position evaluator that reads frames with clock bursts.
 Assumes the device updates data a few cycles after each rising edge. */
`timescale 1ns/1ps
module eeo_ssi_master (
	// Serial link
	output reg ssi_clk,
	input wire ssi_data
);
	// Clock stands high between bursts
	initial ssi_clk = 1'b1;
	// Burst of nbits+1 periods; a bit is taken just before the next rise
	task automatic read_frame(input int nbits, input int half_ns, output logic [31:0] word);
		int i;
		word = 32'h0;
		for (i = 0; i <= nbits; i++) begin
			#(half_ns) ssi_clk = 1'b0;
			#(half_ns);
			if (i > 0)
				word = {word[30:0], ssi_data};
			ssi_clk = 1'b1;
		end
	endtask
endmodule // eeo_ssi_master

// ---- verification/test_encoder_emulation_output.sv ----
/* Self-checking bench for the encoder emulation output.
 Assumes eeo_top, its checker and the serial evaluator model. */
`timescale 1ns/1ps
`include "eeo_defines.vh"
module test_encoder_emulation_output;
	localparam TMO = 50;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg [15:0] shaft_turns = 16'h0;
	reg [15:0] shaft_angle = 16'h0;
	reg enc_index = 1'b0;
	wire [31:0] prdata;
	wire pready, pslverr, out_a, out_b, index_pulse, ssi_clk, ssi_data, nvm_save_req;
	int num_errors = 0, comparisons = 0, cycles = 0, qcount = 0, idx_rises = 0, saves = 0;
	int q0, i0;
	reg [1:0] q_prev = 2'h0;
	reg idx_q = 1'b0;
	logic [31:0] rd;
	logic err;
	wire [1:0] q_idx = {out_a, out_a ^ out_b};
	wire [1:0] q_step = q_idx - q_prev;

	eeo_top #(.TIMEOUT(TMO), .ENC_LOG(11)) u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .shaft_turns(shaft_turns),
		.shaft_angle(shaft_angle), .enc_index(enc_index), .out_a(out_a), .out_b(out_b),
		.index_pulse(index_pulse), .ssi_clk(ssi_clk), .ssi_data(ssi_data),
		.nvm_save_req(nvm_save_req));
	eeo_ssi_master u_master (.ssi_clk(ssi_clk), .ssi_data(ssi_data));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	task wrap_up;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Quadrature position, index and store pulse tally; hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		q_prev <= q_idx;
		idx_q <= index_pulse;
		if (q_step == 2'd1)
			qcount <= qcount + 1;
		if (q_step == 2'd3)
			qcount <= qcount - 1;
		if (index_pulse && !idx_q)
			idx_rises <= idx_rises + 1;
		if (nvm_save_req)
			saves <= saves + 1;
		if (cycles == 40000) begin
			num_errors++;
			wrap_up();
		end
	end

	// One APB transfer; waits for pready rather than assuming zero wait
	task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		// Ends on pready; if it never comes, only the cycle ceiling ends this wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// New shaft position, then the time that many paced steps need
	task move(input logic [31:0] to, input int steps);
		{shaft_turns, shaft_angle} <= to;
		repeat (steps * 40 + 100) @(posedge clk);
	endtask

	task t_regs;
		apb(1'b0, `EEO_OFS_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h0c1);
		apb(1'b0, `EEO_OFS_LINES, 32'h0);
		check("lines reset", rd, 32'h0c);
		apb(1'b0, `EEO_OFS_CLKDIV, 32'h0);
		check("clkdiv reset", rd, 32'h42);
		apb(1'b0, 12'h040, 32'h0);
		check("unmapped error", err, 32'h1);
		apb(1'b1, `EEO_OFS_LINES, 32'h5);
		apb(1'b0, `EEO_OFS_LINES, 32'h0);
		check("lines floor", rd, 32'h08);
		apb(1'b1, `EEO_OFS_LINES, 32'h19);
		apb(1'b0, `EEO_OFS_LINES, 32'h0);
		check("lines ceiling", rd, 32'h13);
	endtask

	// 256 lines: 64 angle units per quadrature state
	task t_incr;
		apb(1'b1, `EEO_OFS_LINES, 32'h8);
		apb(1'b1, `EEO_OFS_IDXOFS, 32'h0100);
		q0 = qcount;
		i0 = idx_rises;
		move(32'h200, 8);
		check("forward steps", qcount - q0, 32'd8);
		check("index once", idx_rises - i0, 32'd1);
		check("offset stored", saves, 32'd1);
		move(32'h0, 8);
		check("reverse steps", qcount - q0, 32'd0);
	endtask

	// Encoder of 2^11 lines times 2^m: 2^(m-3) states per angle unit
	task t_interp;
		int m;
		for (m = 4; m <= 7; m++) begin
			apb(1'b1, `EEO_OFS_CTRL, (m << 9) | 32'h0c3);
			q0 = qcount;
			move(32'h1, 1 << (m - 3));
			check("interp steps", qcount - q0, 1 << (m - 3));
			move(32'h0, 1 << (m - 3));
		end
		i0 = idx_rises;
		enc_index <= 1'b1;
		repeat (6) @(posedge clk);
		enc_index <= 1'b0;
		repeat (8) @(posedge clk);
		check("passed index", idx_rises - i0, 32'd1);
	endtask

	// Every revolution width, Gray on odd widths, latched copy read back
	task t_serial;
		int r;
		logic [31:0] w, exp;
		{shaft_turns, shaft_angle} <= 32'ha5c3_3c5a;
		apb(1'b1, `EEO_OFS_CLKDIV, 32'h2);
		for (r = 12; r <= 16; r++) begin
			apb(1'b1, `EEO_OFS_CTRL, (r << 4) | ((r & 1) << 2) | 2);
			u_master.read_frame(r + 16, 24, w);
			exp = 32'ha5c3_3c5a << (16 - r);
			exp = exp >> (16 - r);
			if (r & 1)
				exp = exp ^ (exp >> 1);
			check("serial frame", w, exp);
			apb(1'b0, `EEO_OFS_POS, 32'h0);
			check("latched frame", rd, exp);
			repeat (TMO * 2) @(posedge clk);
			check("serial idle", ssi_data, 32'h1);
		end
	endtask

	// Edges faster than the set spacing flag overspeed until cleared
	task t_overspeed;
		logic [31:0] w;
		apb(1'b1, `EEO_OFS_CLKDIV, 32'h42);
		u_master.read_frame(28, 24, w);
		repeat (TMO * 2) @(posedge clk);
		apb(1'b0, `EEO_OFS_STATUS, 32'h0);
		check("overspeed set", rd[0], 32'h1);
		apb(1'b1, `EEO_OFS_STATUS, 32'h1);
		apb(1'b0, `EEO_OFS_STATUS, 32'h0);
		check("overspeed clear", rd[0], 32'h0);
	endtask

	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		t_regs;
		t_incr;
		t_interp;
		t_serial;
		t_overspeed;
		wrap_up;
	end
endmodule // test_encoder_emulation_output
